// >>> usb_in_csr_defines.vh
// Constants for the USB IN endpoint control/status block.
// Assumes inclusion by the design, checker and bench files; holds definitions only.
`ifndef USB_IN_CSR_DEFINES_VH
`define USB_IN_CSR_DEFINES_VH

// ****************************************
// Register byte addresses (index times four)
// ****************************************
`define EP0_CSR_IDX 8'h59
`define ADDR_EP0_CSR 12'h164
`define ADDR_INX_CSR 12'h168
`define ADDR_INDEX 12'h16C
`define ADDR_MAX_PACKET_BYTES 12'h170
`define ADDR_IRQ_STAT 12'h174
`define ADDR_IRQ_EN 12'h178
`define ADDR_IRQ_CLR 12'h17C

// ****************************************
// Field positions
// ****************************************
`define EP0_RXP 0
`define EP0_TXP 1
`define EP0_STALL 2
`define EP0_LAST 3
`define EP0_FSTALL 4
`define EP0_EARLY 5
`define EP0_CLR_RX 6
`define EP0_CLR_EARLY 7
`define INX_LOADED 0
`define INX_UNDERRUN 1
`define INX_HALT 2
`define INX_ISO 3
`define INX_RATE 4
`define INX_NOTEMPTY 5
`define INX_FLUSH 6
`define INX_AUTO 7
`define IRQ_STATUS_EVENT 0
`define IRQ_EP0_RX 1
`define IRQ_EP0_EARLY 2

// ****************************************
// Reset values and widths
// ****************************************
`define RST_BYTE 8'h00
`define RST_CNT 2'h0
`define RST_BCNT 10'h000
`define RST_IRQ 3'h0
`define RST_IDX 3'h1
`define MAX_PACKET_BYTES_RST 10'h040
`define NUM_EP 4
`define IRQ_W 3

`endif

// >>> usb_in_csr.v
// USB IN endpoint control/status registers: endpoint 0 and indexed IN 1-4.
// Assumes an APB master on the system clock, and a serial engine / FIFO
// datapath outside that reports token events and FIFO writes as pulses.
//
// Implementation choice: the APB register port.
`default_nettype none
`include "usb_in_csr_defines.vh"

module usb_in_csr (
  input wire CLK_IN, // System clock 50 MHz
  input wire RST_N_IN, // Synchronous reset, active low
  input wire PSEL_IN, // APB select
  input wire PENABLE_IN, // APB access phase
  input wire PWRITE_IN, // APB direction
  input wire [11:0] PADDR_IN, // APB byte address
  input wire [31:0] PWDATA_IN, // APB write data
  output reg [31:0] PRDATA_OUT, // APB read data
  output reg PREADY_OUT, // APB ready
  output reg PSLVERR_OUT, // APB error on unmapped address
  input wire EP0_SETUP_OUT_TOKEN_IN, // Pulse: valid SETUP/OUT token on ep0
  input wire EP0_TX_DONE_IN, // Pulse: ep0 IN packet sent
  input wire EP0_SHORT_END_IN, // Pulse: control transfer ended early
  input wire EP0_STATUS_DONE_IN, // Pulse: status stage completed
  input wire EP0_OVERSIZE_IN, // Pulse: host overran data stage
  input wire [2:0] TOKEN_EP_IN, // Endpoint of IN token / send event
  input wire IN_TOKEN_IN, // Pulse: IN token begins
  input wire TX_DONE_IN, // Pulse: packet sent on TOKEN_EP_IN
  input wire [2:0] WR_EP_IN, // Endpoint written by CPU FIFO write
  input wire FIFO_WR_IN, // Pulse: one byte written into IN FIFO
  output reg [3:0] EP_STALL_OUT, // Halt per endpoint 1-4
  output reg [3:0] EP_ISO_OUT, // Isochronous per endpoint 1-4
  output reg [3:0] EP_RATE_OUT, // Rate feedback per endpoint 1-4
  output reg [3:0] EP_READY_OUT, // Packet ready to send per endpoint
  output reg [3:0] FLUSH_OUT, // Pulse: drop oldest packet
  output reg EP0_STALL_OUT, // Ep0 answers STALL
  output reg EP0_TX_READY_OUT, // Ep0 IN packet ready
  output reg EP0_STATUS_STAGE_OUT, // Ep0 in status stage
  output reg IRQ_OUT // Level interrupt
);

  // ****************************************
  // State
  // ****************************************
  reg [7:0] ep0_r;
  reg [7:0] ep0_nxt;
  reg [2:0] index_r;
  reg [9:0] max_packet_bytes_r;
  reg [1:0] pkt_cnt_r [0:3];
  reg [9:0] byte_cnt_r [0:3];
  reg [3:0] halt_r;
  reg [3:0] iso_r;
  reg [3:0] rate_r;
  reg [3:0] auto_r;
  reg [3:0] underrun_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;
  reg [3:0] full_v;
  reg [3:0] inc_v;
  reg [3:0] dec_v;
  reg [3:0] fl_v;
  integer i;
  integer k;

  // Slot of endpoint 1-4, out of range maps to none
  function [2:0] slot;
    input [2:0] ep;
    begin
      if (ep >= 3'h1 && ep <= 3'h4) begin
        slot = ep - 3'h1;
      end else begin
        slot = 3'h4;
      end
    end
  endfunction

  wire wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  wire [2:0] sel = slot(index_r);
  wire sel_ok = ~sel[2];
  wire [2:0] tok = slot(TOKEN_EP_IN);
  wire [2:0] wrs = slot(WR_EP_IN);
  wire wr_inx = wr && PADDR_IN == `ADDR_INX_CSR && sel_ok;
  wire wr_ep0 = wr && PADDR_IN == `ADDR_EP0_CSR;
  wire mapped = PADDR_IN == `ADDR_EP0_CSR || PADDR_IN == `ADDR_INX_CSR ||
    PADDR_IN == `ADDR_INDEX || PADDR_IN == `ADDR_MAX_PACKET_BYTES ||
    PADDR_IN == `ADDR_IRQ_STAT || PADDR_IN == `ADDR_IRQ_EN ||
    PADDR_IN == `ADDR_IRQ_CLR;

  // ****************************************
  // Endpoint 0 register
  // ****************************************
  always @* begin
    ep0_nxt = ep0_r;
    if (wr_ep0) begin
      ep0_nxt[`EP0_STALL] = PWDATA_IN[`EP0_STALL];
      if (PWDATA_IN[`EP0_TXP]) begin
        ep0_nxt[`EP0_TXP] = 1'b1;
      end
      if (PWDATA_IN[`EP0_LAST]) begin
        ep0_nxt[`EP0_LAST] = 1'b1;
      end
      if (!PWDATA_IN[`EP0_FSTALL]) begin
        ep0_nxt[`EP0_FSTALL] = 1'b0;
      end
      if (PWDATA_IN[`EP0_CLR_RX]) begin
        ep0_nxt[`EP0_RXP] = 1'b0;
      end
      if (PWDATA_IN[`EP0_CLR_EARLY]) begin
        ep0_nxt[`EP0_EARLY] = 1'b0;
      end
    end
    if (EP0_TX_DONE_IN) begin
      ep0_nxt[`EP0_TXP] = 1'b0;
    end
    if (EP0_STATUS_DONE_IN) begin
      ep0_nxt[`EP0_LAST] = 1'b0;
    end
    // set on token, wins over clear
    if (EP0_SETUP_OUT_TOKEN_IN) begin
      ep0_nxt[`EP0_RXP] = 1'b1;
    end
    if (EP0_OVERSIZE_IN) begin
      ep0_nxt[`EP0_FSTALL] = 1'b1;
    end
    if (EP0_SHORT_END_IN) begin
      ep0_nxt[`EP0_EARLY] = 1'b1;
      ep0_nxt[`EP0_TXP] = 1'b0;
    end
    ep0_nxt[`EP0_CLR_RX] = 1'b0;
    ep0_nxt[`EP0_CLR_EARLY] = 1'b0;
  end

  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ep0_r <= `RST_BYTE;
    end else begin
      ep0_r <= ep0_nxt;
    end
  end

  // ****************************************
  // IN endpoints 1-4
  // ****************************************
  // Per-endpoint packet count events, one cycle each
  always @* begin
    full_v = 4'h0;
    inc_v = 4'h0;
    dec_v = 4'h0;
    fl_v = 4'h0;
    for (k = 0; k < `NUM_EP; k = k + 1) begin
      // auto set at max packet size
      full_v[k] = FIFO_WR_IN && wrs == k[2:0] && auto_r[k] &&
        byte_cnt_r[k] + 10'h001 == max_packet_bytes_r;
      fl_v[k] = wr_inx && sel == k[2:0] && PWDATA_IN[`INX_FLUSH] &&
        pkt_cnt_r[k] != `RST_CNT;
      inc_v[k] = (wr_inx && sel == k[2:0] && PWDATA_IN[`INX_LOADED]) || full_v[k];
      dec_v[k] = TX_DONE_IN && tok == k[2:0] && pkt_cnt_r[k] != `RST_CNT;
    end
  end

  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      halt_r <= 4'h0;
      iso_r <= 4'h0;
      rate_r <= 4'h0;
      auto_r <= 4'h0;
      underrun_r <= 4'h0;
      FLUSH_OUT <= 4'h0;
      for (i = 0; i < `NUM_EP; i = i + 1) begin
        pkt_cnt_r[i] <= `RST_CNT;
        byte_cnt_r[i] <= `RST_BCNT;
      end
    end else begin
      FLUSH_OUT <= fl_v;
      for (i = 0; i < `NUM_EP; i = i + 1) begin
        // Byte count restarts when a packet completes
        if (full_v[i]) begin
          byte_cnt_r[i] <= `RST_BCNT;
        end else if (FIFO_WR_IN && wrs == i[2:0]) begin
          byte_cnt_r[i] <= byte_cnt_r[i] + 10'h001;
        end
        if (wr_inx && sel == i[2:0]) begin
          halt_r[i] <= PWDATA_IN[`INX_HALT];
          iso_r[i] <= PWDATA_IN[`INX_ISO];
          rate_r[i] <= PWDATA_IN[`INX_RATE];
          auto_r[i] <= PWDATA_IN[`INX_AUTO];
          // CPU packet-loaded write restarts the byte count
          if (PWDATA_IN[`INX_LOADED]) begin
            byte_cnt_r[i] <= `RST_BCNT;
          end
        end
        // Packet count 0..2, one drop per cycle
        if ((inc_v[i] && pkt_cnt_r[i] != 2'h2) && !(dec_v[i] || fl_v[i])) begin
          pkt_cnt_r[i] <= pkt_cnt_r[i] + 2'h1;
        end else if (!(inc_v[i] && pkt_cnt_r[i] != 2'h2) && (dec_v[i] || fl_v[i])) begin
          pkt_cnt_r[i] <= pkt_cnt_r[i] - 2'h1;
        end
        if (wr_inx && sel == i[2:0] && !PWDATA_IN[`INX_UNDERRUN]) begin
          underrun_r[i] <= 1'b0;
        end
        if (IN_TOKEN_IN && tok == i[2:0] && iso_r[i] && pkt_cnt_r[i] == `RST_CNT) begin
          underrun_r[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Index, max packet and interrupts
  // ****************************************
  wire [2:0] irq_set = {EP0_SHORT_END_IN, EP0_SETUP_OUT_TOKEN_IN,
    IN_TOKEN_IN && !tok[2] && iso_r[tok[1:0]] && pkt_cnt_r[tok[1:0]] == `RST_CNT};

  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      index_r <= `RST_IDX;
      max_packet_bytes_r <= `MAX_PACKET_BYTES_RST;
      irq_stat_r <= `RST_IRQ;
      irq_en_r <= `RST_IRQ;
    end else begin
      if (wr && PADDR_IN == `ADDR_INDEX) begin
        index_r <= PWDATA_IN[2:0];
      end
      if (wr && PADDR_IN == `ADDR_MAX_PACKET_BYTES) begin
        max_packet_bytes_r <= PWDATA_IN[9:0];
      end
      if (wr && PADDR_IN == `ADDR_IRQ_EN) begin
        irq_en_r <= PWDATA_IN[`IRQ_W-1:0];
      end
      // status event; set wins over clear
      if (wr && PADDR_IN == `ADDR_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~PWDATA_IN[`IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  // ****************************************
  // Outputs and APB read path
  // ****************************************
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h00000000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      EP_STALL_OUT <= 4'h0;
      EP_ISO_OUT <= 4'h0;
      EP_RATE_OUT <= 4'h0;
      EP_READY_OUT <= 4'h0;
      EP0_STALL_OUT <= 1'b0;
      EP0_TX_READY_OUT <= 1'b0;
      EP0_STATUS_STAGE_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      // Answer in the first access cycle
      PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~mapped;
      if (rd) begin
        PRDATA_OUT <= 32'h00000000;
        case (PADDR_IN)
          `ADDR_EP0_CSR: PRDATA_OUT[7:0] <= ep0_nxt;
          `ADDR_INX_CSR: begin
            if (sel_ok) begin
              PRDATA_OUT[7:0] <= {auto_r[sel[1:0]], 1'b0,
                pkt_cnt_r[sel[1:0]] != `RST_CNT || byte_cnt_r[sel[1:0]] != `RST_BCNT,
                rate_r[sel[1:0]], iso_r[sel[1:0]], halt_r[sel[1:0]],
                underrun_r[sel[1:0]], pkt_cnt_r[sel[1:0]] == 2'h2};
            end
          end
          `ADDR_INDEX: PRDATA_OUT[2:0] <= index_r;
          `ADDR_MAX_PACKET_BYTES: PRDATA_OUT[9:0] <= max_packet_bytes_r;
          `ADDR_IRQ_STAT: PRDATA_OUT[`IRQ_W-1:0] <= irq_stat_r;
          `ADDR_IRQ_EN: PRDATA_OUT[`IRQ_W-1:0] <= irq_en_r;
          default: PRDATA_OUT <= 32'h00000000;
        endcase
      end
      EP_STALL_OUT <= halt_r;
      EP_ISO_OUT <= iso_r;
      EP_RATE_OUT <= rate_r;
      EP_READY_OUT <= {pkt_cnt_r[3] != `RST_CNT, pkt_cnt_r[2] != `RST_CNT,
        pkt_cnt_r[1] != `RST_CNT, pkt_cnt_r[0] != `RST_CNT};
      EP0_STALL_OUT <= ep0_r[`EP0_STALL] | ep0_r[`EP0_FSTALL];
      EP0_TX_READY_OUT <= ep0_r[`EP0_TXP];
      EP0_STATUS_STAGE_OUT <= ep0_r[`EP0_LAST];
      IRQ_OUT <= |(irq_stat_r & irq_en_r);
    end
  end

endmodule
`default_nettype wire

// >>> usb_in_csr_assertions.sv
// Checker: APB answer and endpoint 0 output relations of the IN CSR block.
// Assumes binding to usb_in_csr; sees only its ports.
`default_nettype none
`include "usb_in_csr_defines.vh"
module usb_in_csr_assertions (
  input wire logic CLK_IN, // Clock
  input wire logic RST_N_IN, // Sync reset, low
  input wire logic PSEL_IN, // Select
  input wire logic PENABLE_IN, // Access phase
  input wire logic PWRITE_IN, // Direction
  input wire logic [11:0] PADDR_IN, // Address
  input wire logic [31:0] PWDATA_IN, // Write data
  input wire logic [31:0] PRDATA_OUT, // Read data
  input wire logic PREADY_OUT, // Ready
  input wire logic PSLVERR_OUT, // Error
  input wire logic EP0_STATUS_DONE_IN, // Status stage done
  input wire logic [3:0] FLUSH_OUT, // Flush pulses
  input wire logic EP0_STALL_OUT, // Ep0 stall
  input wire logic EP0_STATUS_STAGE_OUT // Ep0 status stage
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ****
  // Bus steps
  // ****
  sequence setup_s;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence ep0_wr_s(b);
    PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == `ADDR_EP0_CSR && b;
  endsequence
  sequence rd_s;
    PREADY_OUT && !PWRITE_IN;
  endsequence
  // ****
  // Properties
  // ****
  ready_after_setup_a: assert property (setup_s |=> PREADY_OUT)
    else $error("no zero-wait answer");
  error_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  upper_bits_zero_a: assert property (rd_s |-> PRDATA_OUT[31:8] == 24'h000000)
    else $error("upper read bits set");
  clear_bits_zero_a: assert property (rd_s ##0 PADDR_IN == `ADDR_EP0_CSR |-> PRDATA_OUT[7:6] == 2'h0)
    else $error("ep0 clear bits read set");
  flush_reads_zero_a: assert property (rd_s ##0 PADDR_IN == `ADDR_INX_CSR |-> !PRDATA_OUT[6])
    else $error("flush bit read set");
  flush_one_cycle_a: assert property (|FLUSH_OUT |=> FLUSH_OUT == 4'h0)
    else $error("flush pulse too long");
  stall_set_a: assert property (ep0_wr_s(PWDATA_IN[2]) |=> ##1 EP0_STALL_OUT)
    else $error("ep0 stall not shown");
  status_enter_a: assert property (ep0_wr_s(PWDATA_IN[3] && !EP0_STATUS_DONE_IN)
    ##1 !EP0_STATUS_DONE_IN |=> EP0_STATUS_STAGE_OUT)
    else $error("status stage not entered");
  status_leave_a: assert property (EP0_STATUS_DONE_IN && !PSEL_IN |-> ##2 !EP0_STATUS_STAGE_OUT)
    else $error("status stage not left");
endmodule
bind usb_in_csr usb_in_csr_assertions chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .EP0_STATUS_DONE_IN(EP0_STATUS_DONE_IN), .FLUSH_OUT(FLUSH_OUT),
  .EP0_STALL_OUT(EP0_STALL_OUT), .EP0_STATUS_STAGE_OUT(EP0_STATUS_STAGE_OUT));
`default_nettype wire

// >>> usb_host_model.sv
// Host model: IN tokens, packet-sent and endpoint 0 events as pulses.
// Assumes the bench calls its tasks; outputs feed the block's event inputs.
`default_nettype none
module usb_host_model (
  input wire logic clk_in, // Clock
  output logic [2:0] tok_ep_out, // Token endpoint
  output logic in_tok_out, // IN token begins
  output logic tx_done_out, // Packet sent
  output logic [4:0] ep0_ev_out // Ep0 event pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle outputs
  initial begin
    tok_ep_out = 3'h0;
    in_tok_out = 1'b0;
    tx_done_out = 1'b0;
    ep0_ev_out = 5'h00;
  end
  // Token or sent pulse after a gap; endpoint scrambled once idle
  task automatic token(input logic [2:0] ep, input logic sent, input int gap);
    repeat (gap) @(posedge clk_in);
    tok_ep_out <= ep;
    in_tok_out <= !sent;
    tx_done_out <= sent;
    @(posedge clk_in);
    tok_ep_out <= ~ep;
    in_tok_out <= 1'b0;
    tx_done_out <= 1'b0;
  endtask
  // Ep0 pulse: 0 setup, 1 sent, 2 short end, 3 status done, 4 oversize
  task automatic ep0_event(input int b);
    @(posedge clk_in);
    ep0_ev_out <= 5'h01 << b;
    @(posedge clk_in);
    ep0_ev_out <= 5'h00;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Bench for the USB IN endpoint CSR block: APB master, FIFO writer, host.
// Assumes usb_in_csr, usb_host_model and the bound checker are compiled.
`default_nettype none
`include "usb_in_csr_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fwr = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, perr, irq, e0stall, e0txr, e0stage, itok, txd;
  logic [2:0] wep = 3'h0, tep;
  logic [4:0] ev;
  logic [3:0] stall, iso, rate, rdy, flush;
  int n_fail = 0, n_compared = 0, seed = 32'h013A;
  // Clock
  always #10 clk = ~clk;
  usb_host_model host (.clk_in(clk), .tok_ep_out(tep), .in_tok_out(itok),
    .tx_done_out(txd), .ep0_ev_out(ev));
  usb_in_csr dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .EP0_SETUP_OUT_TOKEN_IN(ev[0]),
    .EP0_TX_DONE_IN(ev[1]), .EP0_SHORT_END_IN(ev[2]), .EP0_STATUS_DONE_IN(ev[3]),
    .EP0_OVERSIZE_IN(ev[4]), .TOKEN_EP_IN(tep), .IN_TOKEN_IN(itok), .TX_DONE_IN(txd),
    .WR_EP_IN(wep), .FIFO_WR_IN(fwr), .EP_STALL_OUT(stall), .EP_ISO_OUT(iso),
    .EP_RATE_OUT(rate), .EP_READY_OUT(rdy), .FLUSH_OUT(flush), .EP0_STALL_OUT(e0stall),
    .EP0_TX_READY_OUT(e0txr), .EP0_STATUS_STAGE_OUT(e0stage), .IRQ_OUT(irq));
  // ****
  // Tasks
  // ****
  task automatic print_verdict;
    $display("fails %0d compares %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Byte writes into one endpoint FIFO, then settle
  task automatic fw(input logic [2:0] ep, input int n);
    repeat (n) begin
      @(posedge clk);
      wep <= ep;
      fwr <= 1'b1;
      @(posedge clk);
      fwr <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  // Readback of a config write: flags clear, strobe and underrun keep reading 0
  function automatic logic [31:0] inx_exp(input logic [7:0] d);
    return {24'h000000, d & 8'h9C};
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    logic [7:0] c;
    int ep;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`ADDR_EP0_CSR, 32'h0);
    rchk(`ADDR_INX_CSR, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(er, 32'h1);
    for (int k = 0; k < 8; k++) begin
      ep = k % 4 + 1;
      c = (8'($random(seed)) & 8'h9C) | 8'h02;
      wr(`ADDR_INDEX, ep);
      wr(`ADDR_INX_CSR, c);
      rchk(`ADDR_INX_CSR, inx_exp(c));
      chk({rate[ep-1], iso[ep-1], stall[ep-1]}, c[4:2]);
    end
    wr(`ADDR_INDEX, 0);
    rchk(`ADDR_INX_CSR, 32'h0);
    // Underrun only on an iso endpoint, with interrupt
    wr(`ADDR_IRQ_EN, 7);
    wr(`ADDR_INDEX, 2);
    wr(`ADDR_INX_CSR, 8'h02);
    host.token(2, 1'b0, 3);
    rchk(`ADDR_INX_CSR, 32'h0);
    wr(`ADDR_INDEX, 1);
    wr(`ADDR_INX_CSR, 8'h0A);
    host.token(1, 1'b0, 0);
    rchk(`ADDR_INX_CSR, 32'h0A);
    chk(irq, 32'h1);
    rchk(`ADDR_IRQ_STAT, 32'h1);
    wr(`ADDR_INX_CSR, 8'h08);
    wr(`ADDR_IRQ_CLR, 1);
    rchk(`ADDR_INX_CSR, 32'h08);
    chk(irq, 32'h0);
    // Auto-set, occupancy, send and flush on endpoint 3
    wr(`ADDR_MAX_PACKET_BYTES, 4);
    wr(`ADDR_INDEX, 3);
    wr(`ADDR_INX_CSR, 8'h82);
    fw(3, 3);
    chk(rdy[2], 32'h0);
    rchk(`ADDR_INX_CSR, 32'hA0);
    fw(3, 5);
    chk(rdy[2], 32'h1);
    fw(3, 3);
    rchk(`ADDR_INX_CSR, 32'hA1);
    host.token(3, 1'b1, $random(seed) & 3);
    rchk(`ADDR_INX_CSR, 32'hA0);
    fw(3, 1);
    wr(`ADDR_INX_CSR, 8'hC2);
    @(negedge clk);
    chk(flush, 32'h4);
    rchk(`ADDR_INX_CSR, 32'hA0);
    wr(`ADDR_INX_CSR, 8'hC2);
    @(negedge clk);
    chk(flush, 32'h4);
    rchk(`ADDR_INX_CSR, 32'h80);
    chk(rdy[2], 32'h0);
    // CPU packet-loaded writes on endpoint 4
    wr(`ADDR_INDEX, 4);
    fw(4, 2);
    wr(`ADDR_INX_CSR, 8'h03);
    rchk(`ADDR_INX_CSR, 32'h20);
    wr(`ADDR_INX_CSR, 8'h03);
    rchk(`ADDR_INX_CSR, 32'h21);
    chk(rdy[3], 32'h1);
    // Endpoint 0 flags, clears, stall and status stage
    host.ep0_event(0);
    rchk(`ADDR_EP0_CSR, 32'h01);
    chk(irq, 32'h1);
    wr(`ADDR_EP0_CSR, 8'h40);
    rchk(`ADDR_EP0_CSR, 32'h00);
    host.ep0_event(2);
    rchk(`ADDR_EP0_CSR, 32'h20);
    wr(`ADDR_EP0_CSR, 8'h80);
    rchk(`ADDR_EP0_CSR, 32'h00);
    wr(`ADDR_EP0_CSR, 8'h0C);
    rchk(`ADDR_EP0_CSR, 32'h0C);
    chk({e0stall, e0stage}, 32'h3);
    host.ep0_event(3);
    rchk(`ADDR_EP0_CSR, 32'h04);
    wr(`ADDR_EP0_CSR, 8'h00);
    rchk(`ADDR_EP0_CSR, 32'h00);
    chk({e0stall, e0stage}, 32'h0);
    // Ep0 packet loaded then sent; oversize forces stall
    wr(`ADDR_EP0_CSR, 8'h02);
    rchk(`ADDR_EP0_CSR, 32'h02);
    chk(e0txr, 32'h1);
    host.ep0_event(1);
    rchk(`ADDR_EP0_CSR, 32'h00);
    chk(e0txr, 32'h0);
    host.ep0_event(4);
    rchk(`ADDR_EP0_CSR, 32'h10);
    chk(e0stall, 32'h1);
    wr(`ADDR_EP0_CSR, 8'h00);
    rchk(`ADDR_EP0_CSR, 32'h00);
    chk(e0stall, 32'h0);
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
